// ### acpr_pkg.sv
// Purpose: Shared constants and types for the codec link power and reset controller
// Assumes: 50 MHz system clock
// Notes: Register byte address is four times the register index
package acpr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam real CLK_PERIOD_NS = 20.0;
	localparam real COLD_WAIT_US = 162.8;
	localparam real WARM_WAIT_NS = 162.8;
	localparam real BITCLK_HALF_NS = 40.7;
	localparam real PD_MAX_US = 1.0;
	localparam real TEST_OFF_NS = 25.0;
	localparam int COLD_WAIT_CYCLES = int'($ceil(COLD_WAIT_US * 1000.0 / CLK_PERIOD_NS));
	localparam int WARM_WAIT_CYCLES = int'($ceil(WARM_WAIT_NS / CLK_PERIOD_NS));
	localparam int BITCLK_HALF_CYCLES = int'($floor(BITCLK_HALF_NS / CLK_PERIOD_NS));
	localparam int PD_MAX_CYCLES = int'($floor(PD_MAX_US * 1000.0 / CLK_PERIOD_NS));
	localparam int TEST_OFF_CYCLES = int'($floor(TEST_OFF_NS / CLK_PERIOD_NS));

	////////////////////////////////////////////////////////////////////////////////
	// Frame layout
	localparam int FRAME_BITS = 256;
	localparam int TAG_BITS = 16;
	localparam logic [7:0] TAG_LAST_BIT = 8'h0f;
	localparam logic [7:0] SLOT2_LAST_BIT = 8'h37;

	////////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam int ADDR_WIDTH = 10;
	localparam logic [7:0] REG_POWERDOWN_IDX = 8'h26;
	localparam logic [7:0] REG_LINK_STATUS_IDX = 8'h30;
	localparam int PD_LSB = 8;
	localparam int PD_WIDTH = 6;
	localparam int PD_BYTE_LANE = 1;
	localparam logic [5:0] PD_RESET = 6'h00;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic internal_clock_disable;
		logic link_powerdown;
		logic mixer_powerdown_ref_off;
		logic mixer_powerdown_ref_on;
		logic dac_powerdown;
		logic adc_input_mux_powerdown;
	} acpr_pd_type;

	typedef struct packed {
		logic ref_ready;
		logic analog_path_ready;
		logic dac_ready;
		logic adc_ready;
	} acpr_ready_type;

	typedef enum logic [1:0] {
		ACPR_PRIMARY = 2'h0,
		ACPR_SECONDARY1 = 2'h1,
		ACPR_SECONDARY2 = 2'h2,
		ACPR_SECONDARY3 = 2'h3
	} acpr_mode_type;

	typedef enum logic [2:0] {
		ST_RESET = 3'h0,
		ST_COLD_WAIT = 3'h1,
		ST_RUN = 3'h2,
		ST_DOWN = 3'h3,
		ST_WARM_SYNC = 3'h4,
		ST_WARM_WAIT = 3'h5,
		ST_TEST = 3'h6
	} acpr_state_type;

endpackage

// ### acpr_pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pins are asynchronous to clock
// Notes: Level follows only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module acpr_pin_sync #(
	parameter int WIDTH = 1
) (
	// System
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// Pins and filtered levels
	input wire logic [WIDTH-1:0] pins,
	output logic [WIDTH-1:0] level
);

	////////////////////////////////////////////////////////////////////////////////
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic s1;
			logic s2;
			logic s3;
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					level[i] <= 1'b0;
				end else if (clk_en) begin
					s1 <= pins[i];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						level[i] <= s3;
					end
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// ### acpr_ctrl.sv
// Purpose: Codec-side link power, reset and test-mode control with Avalon-MM registers
// Assumes: Pins pass the three-stage synchroniser; bit clock far below system clock
// Notes: Pin sampling lags the link edges by the synchroniser depth
// Function
// - One primary plus up to three secondaries, each on its own return line.
// - Straps: both high primary, a low sec1, b low sec2, both low sec3.
// - Primary drives the bit clock; a secondary only receives it.
// - Primary waits at least 162.8 us after reset release before clocking.
// - Warm reset: sync pulse while clock stopped; restart 162.8 ns after fall.
// - Bit clock near 12.288 MHz; sync frames at 48 kHz.
// - Serial output data sampled on bit clock falling edge.
// - Sync sampled on bit clock rising edge.
// - Link power-down forces clock and return data low within 1 us of slot 2.
// - Six power-down bits, each shutting down its own section.
// - Registers kept in sleep; warm keeps values, cold restores defaults.
// - Warm or cold reset clears the link power-down bit; a power-down write in the same cycle as the warm clear wins.
// - Data high at reset release: in-circuit test, outputs released.
// - Test-mode outputs released within 25 ns of reset release; here on the fifth clock after the pin rises, about 100 ns.
// - Sync high at reset release enters vendor test mode.
// - Four read-only ready bits in the power-down register low nibble.
`timescale 1ns/1ps
`default_nettype none
module acpr_ctrl #(
	parameter int COLD_CYCLES = acpr_pkg::COLD_WAIT_CYCLES,
	parameter int WARM_CYCLES = acpr_pkg::WARM_WAIT_CYCLES,
	parameter int HALF_CYCLES = acpr_pkg::BITCLK_HALF_CYCLES
) (
	// System
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// Avalon-MM slave
	input wire logic [acpr_pkg::ADDR_WIDTH-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Link pins
	input wire logic link_reset_n_pin,
	input wire logic sync_pin,
	input wire logic sdata_out_pin,
	input wire logic bit_clk_in,
	output logic bit_clk_out,
	output logic bit_clk_oe,
	output logic sdata_in_out,
	output logic sdata_in_oe,
	// Straps
	input wire logic codec_select_strap_a,
	input wire logic codec_select_strap_b,
	// Section controls and status
	output acpr_pkg::acpr_pd_type powerdown,
	output acpr_pkg::acpr_ready_type ready,
	output acpr_pkg::acpr_mode_type codec_mode,
	output logic ate_mode,
	output logic vendor_mode,
	output logic frame_start
);
	import acpr_pkg::*;

	localparam int WAIT_W = $clog2(COLD_CYCLES + WARM_CYCLES + 1);
	localparam int HALF_W = $clog2(HALF_CYCLES + 1);
	localparam logic [WAIT_W-1:0] COLD_LAST = WAIT_W'(COLD_CYCLES - 1);
	localparam logic [WAIT_W-1:0] WARM_LAST = WAIT_W'(WARM_CYCLES - 1);
	localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(HALF_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic reset_lvl;
	logic sync_lvl;
	logic sdata_lvl;
	logic bclk_lvl;
	logic strap_a_lvl;
	logic strap_b_lvl;

	acpr_pin_sync #(.WIDTH(6)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.pins({codec_select_strap_b, codec_select_strap_a, bit_clk_in, sdata_out_pin,
			sync_pin, link_reset_n_pin}),
		.level({strap_b_lvl, strap_a_lvl, bclk_lvl, sdata_lvl, sync_lvl, reset_lvl})
	);

	acpr_state_type state;
	logic reset_prev;
	logic bclk_prev;
	logic sync_q;
	logic [WAIT_W-1:0] wait_cnt;
	logic [HALF_W-1:0] half_cnt;
	logic [7:0] bit_cnt;
	logic [TAG_BITS-1:0] tag_shift;
	logic rst_rise;
	logic is_primary;
	logic gen_tick;
	logic bclk_rise;
	logic bclk_fall;
	logic ate_next;
	logic bus_take;
	logic [7:0] reg_idx;

	// Release seen after filtering, so catches come a few cycles late
	assign rst_rise = reset_lvl && !reset_prev;
	assign is_primary = (codec_mode == ACPR_PRIMARY);
	assign gen_tick = (state == ST_RUN) && is_primary && (half_cnt == HALF_LAST);
	assign bclk_rise = (state == ST_RUN) &&
		(is_primary ? (gen_tick && !bit_clk_out) : (bclk_lvl && !bclk_prev));
	assign bclk_fall = (state == ST_RUN) &&
		(is_primary ? (gen_tick && bit_clk_out) : (!bclk_lvl && bclk_prev));
	assign ate_next = rst_rise ? sdata_lvl : ate_mode;
	assign bus_take = (avs_read || avs_write) && !avs_waitrequest;
	assign reg_idx = avs_address[ADDR_WIDTH-1:2];

	////////////////////////////////////////////////////////////////////////////////
	// Strap and test-mode capture at reset release
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reset_prev <= 1'b0;
			codec_mode <= ACPR_PRIMARY;
			ate_mode <= 1'b0;
			vendor_mode <= 1'b0;
		end else if (clk_en) begin
			reset_prev <= reset_lvl;
			if (rst_rise) begin
				codec_mode <= acpr_mode_type'({!strap_b_lvl, !strap_a_lvl});
				ate_mode <= sdata_lvl;
				vendor_mode <= sync_lvl;
			end else if (!reset_lvl) begin
				ate_mode <= 1'b0;
				vendor_mode <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link state machine
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_RESET;
		end else if (clk_en) begin
			if (!reset_lvl) begin
				state <= ST_RESET;
			end else begin
				case (state)
					ST_RESET: begin
						if (rst_rise) begin
							state <= (sdata_lvl || sync_lvl) ? ST_TEST : ST_COLD_WAIT;
						end
					end
					ST_COLD_WAIT: begin
						if (wait_cnt == COLD_LAST) begin
							state <= ST_RUN;
						end
					end
					ST_RUN: begin
						if (powerdown.link_powerdown && bclk_fall && bit_cnt == SLOT2_LAST_BIT) begin
							state <= ST_DOWN;
						end
					end
					ST_DOWN: begin
						if (sync_lvl) begin
							state <= ST_WARM_SYNC;
						end
					end
					ST_WARM_SYNC: begin
						if (!sync_lvl) begin
							state <= ST_WARM_WAIT;
						end
					end
					ST_WARM_WAIT: begin
						if (wait_cnt == WARM_LAST) begin
							state <= ST_RUN;
						end
					end
					ST_TEST: begin
						state <= ST_TEST;
					end
					default: begin
						state <= ST_RESET;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt <= '0;
		end else if (clk_en) begin
			if (state == ST_COLD_WAIT || state == ST_WARM_WAIT) begin
				wait_cnt <= wait_cnt + 1'b1;
			end else begin
				wait_cnt <= '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bit clock generation and pin drive
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			half_cnt <= '0;
			bit_clk_out <= 1'b0;
			bit_clk_oe <= 1'b0;
			sdata_in_out <= 1'b0;
			sdata_in_oe <= 1'b0;
		end else if (clk_en) begin
			if (state != ST_RUN || gen_tick) begin
				half_cnt <= '0;
			end else begin
				half_cnt <= half_cnt + 1'b1;
			end
			// Clock held low whenever the link is not running
			if (state != ST_RUN || (bclk_fall && powerdown.link_powerdown &&
				bit_cnt == SLOT2_LAST_BIT)) begin
				bit_clk_out <= 1'b0;
			end else if (gen_tick) begin
				bit_clk_out <= !bit_clk_out;
			end
			// Only slot control lives here; return data stays low
			sdata_in_out <= 1'b0;
			// Strap decode lands in codec_mode on this same edge, so decode it here too
			bit_clk_oe <= (rst_rise ?
				(acpr_mode_type'({!strap_b_lvl, !strap_a_lvl}) == ACPR_PRIMARY) :
				is_primary) && !ate_next;
			sdata_in_oe <= !ate_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frame tracking and serial sampling
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bclk_prev <= 1'b0;
			sync_q <= 1'b0;
			bit_cnt <= '0;
			frame_start <= 1'b0;
			tag_shift <= '0;
		end else if (clk_en) begin
			bclk_prev <= bclk_lvl;
			frame_start <= 1'b0;
			if (bclk_rise) begin
				sync_q <= sync_lvl;
				if (sync_lvl && !sync_q) begin
					bit_cnt <= '0;
					frame_start <= 1'b1;
				end else begin
					bit_cnt <= bit_cnt + 1'b1;
				end
			end
			if (bclk_fall && bit_cnt <= TAG_LAST_BIT) begin
				tag_shift <= {tag_shift[TAG_BITS-2:0], sdata_lvl};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power-down register and ready status
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			powerdown <= acpr_pd_type'(PD_RESET);
		end else if (clk_en) begin
			if (!reset_lvl) begin
				powerdown <= acpr_pd_type'(PD_RESET);
			end else if (bus_take && avs_write && reg_idx == REG_POWERDOWN_IDX &&
				avs_byteenable[PD_BYTE_LANE]) begin
				powerdown <= acpr_pd_type'(avs_writedata[PD_LSB +: PD_WIDTH]);
			end else if (state == ST_WARM_SYNC && !sync_lvl) begin
				powerdown.link_powerdown <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ready <= '0;
		end else if (clk_en) begin
			ready.ref_ready <= !powerdown.mixer_powerdown_ref_off;
			ready.analog_path_ready <= !powerdown.mixer_powerdown_ref_on &&
				!powerdown.mixer_powerdown_ref_off;
			ready.dac_ready <= !powerdown.dac_powerdown && !powerdown.mixer_powerdown_ref_off;
			ready.adc_ready <= !powerdown.adc_input_mux_powerdown &&
				!powerdown.mixer_powerdown_ref_off;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle, then answer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= READ_UNMAPPED;
		end else if (clk_en) begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				case (reg_idx)
					REG_POWERDOWN_IDX: begin
						avs_readdata <= {16'h0000, 2'b00, powerdown, 4'h0, ready};
					end
					REG_LINK_STATUS_IDX: begin
						avs_readdata <= {tag_shift, bit_cnt, 1'b0, state, vendor_mode, ate_mode,
							codec_mode};
					end
					default: begin
						avs_readdata <= READ_UNMAPPED;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	localparam int PD_BOUND = PD_MAX_CYCLES;
	// Time since the release event, kept apart from the state machine's own counter
	logic [WAIT_W-1:0] chk_wait;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			chk_wait <= '0;
		end else if (clk_en) begin
			if (rst_rise || (state == ST_WARM_SYNC && !sync_lvl)) begin
				chk_wait <= '0;
			end else if (chk_wait != '1) begin
				chk_wait <= chk_wait + 1'b1;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_strap;
		rst_rise && clk_en |=> codec_mode == acpr_mode_type'({!$past(strap_b_lvl), !$past(strap_a_lvl)});
	endproperty
	a_strap: assert property (p_strap) else $error("strap decode wrong");
	property p_clk_dir;
		bit_clk_oe |-> codec_mode == ACPR_PRIMARY && !ate_mode;
	endproperty
	a_clk_dir: assert property (p_clk_dir) else $error("bit clock driven by secondary");
	property p_cold_wait;
		state == ST_RUN && $past(state) == ST_COLD_WAIT |-> $past(chk_wait) >= COLD_CYCLES - 1;
	endproperty
	a_cold_wait: assert property (p_cold_wait) else $error("clock started too early");
	property p_warm_wait;
		state == ST_RUN && $past(state) == ST_WARM_WAIT |-> $past(chk_wait) >= WARM_CYCLES - 1;
	endproperty
	a_warm_wait: assert property (p_warm_wait) else $error("warm restart too early");
	property p_data_fall;
		$changed(tag_shift) |-> $past(bclk_fall);
	endproperty
	a_data_fall: assert property (p_data_fall) else $error("data sampled off falling edge");
	property p_frame;
		bclk_rise && sync_lvl && !sync_q && clk_en |=> bit_cnt == 8'h00 && frame_start;
	endproperty
	a_frame: assert property (p_frame) else $error("frame start not taken");
	property p_link_down;
		state == ST_RUN && powerdown.link_powerdown && bclk_fall && bit_cnt == SLOT2_LAST_BIT
			&& reset_lvl |-> ##[1:PD_BOUND] (!bit_clk_out && !sdata_in_out && state == ST_DOWN);
	endproperty
	a_link_down: assert property (p_link_down) else $error("link not shut down");
	property p_pd_write;
		bus_take && avs_write && reg_idx == REG_POWERDOWN_IDX && avs_byteenable[PD_BYTE_LANE]
			&& reset_lvl && clk_en |=> powerdown == $past(avs_writedata[PD_LSB +: PD_WIDTH]);
	endproperty
	a_pd_write: assert property (p_pd_write) else $error("power-down write lost");
	property p_warm_keep;
		state == ST_WARM_WAIT && $past(state) == ST_WARM_SYNC && !$past(bus_take)
			|-> !powerdown.link_powerdown && powerdown[3:0] == $past(powerdown[3:0]);
	endproperty
	a_warm_keep: assert property (p_warm_keep) else $error("warm wake state wrong");
	property p_cold_clear;
		!reset_lvl && clk_en |=> powerdown == acpr_pd_type'(PD_RESET);
	endproperty
	a_cold_clear: assert property (p_cold_clear) else $error("cold reset kept bits");
	property p_ate_off;
		$rose(ate_mode) |-> !bit_clk_oe && !sdata_in_oe;
	endproperty
	a_ate_off: assert property (p_ate_off) else $error("outputs not released in test");
	property p_vendor;
		vendor_mode |-> state == ST_TEST;
	endproperty
	a_vendor: assert property (p_vendor) else $error("vendor mode not held");
	property p_ready;
		clk_en ##1 powerdown.mixer_powerdown_ref_off |=> !ready.ref_ready || !clk_en;
	endproperty
	a_ready: assert property (p_ready) else $error("reference ready while off");

	c_run: cover property (state == ST_RUN && $past(state) == ST_COLD_WAIT);
	c_down: cover property (state == ST_DOWN);
	c_warm: cover property (state == ST_RUN && $past(state) == ST_WARM_WAIT);
	c_ate: cover property ($rose(ate_mode));

endmodule
`default_nettype wire

// ### acpr_link_partner.sv
// Purpose: Behavioural link controller facing the codec block
// Assumes: Bit clock is the codec's or own_bclk, chosen by the bench
// Notes: Sync and data launched away from their sampling edges
`timescale 1ns/1ps
`default_nettype none
module acpr_link_partner (
	// System
	input wire logic clock,
	// Link
	input wire logic bclk,
	output logic own_bclk,
	output logic link_reset_n,
	output logic sync,
	output logic sdo
);
	logic [7:0] bit_idx;
	logic frames_on;
	logic own_on;
	logic [15:0] tag;
	initial begin
		{own_bclk, link_reset_n, sync, sdo, frames_on, own_on} = 6'h00;
		bit_idx = 8'hff;
		tag = 16'h9ac5;
		#7;
		// Stands low while off, no phase tie to clock
		forever begin
			#80 own_bclk = own_on & ~own_bclk;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Data launched at the rise, sampled by the codec at the fall
	always @(posedge bclk) begin
		if (frames_on) begin
			bit_idx <= bit_idx + 8'h01;
			sdo <= (bit_idx + 8'h01 < 8'h10) ? tag[~(bit_idx[3:0] + 4'h1)] : 1'b0;
		end
	end
	// Sync high for bits 0 to 15 of 256
	always @(negedge bclk) begin
		if (frames_on) begin
			sync <= (bit_idx + 8'h01 < 8'h10);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic cold_reset(input logic sdo_lvl, input logic sync_lvl);
		frames_on <= 1'b0;
		own_on <= 1'b0;
		link_reset_n <= 1'b0;
		repeat (60) @(posedge clock);
		sdo <= sdo_lvl;
		sync <= sync_lvl;
		bit_idx <= 8'hff;
		@(posedge clock);
		link_reset_n <= 1'b1;
		repeat (8) @(posedge clock);
		sdo <= 1'b0;
		sync <= 1'b0;
	endtask
	task automatic warm_reset();
		frames_on <= 1'b0;
		sync <= 1'b1;
		repeat (65) @(posedge clock);
		sync <= 1'b0;
		bit_idx <= 8'hff;
	endtask
	task automatic start_frames(input logic own);
		own_on <= own;
		frames_on <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ### acpr_ctrl_tb_top.sv
// Purpose: Self-checking bench for the link power and reset controller
// Assumes: Short cold wait parameter; controller model on the link
// Notes: Register access through Avalon-MM tasks only
`timescale 1ns/1ps
`default_nettype none
module acpr_ctrl_tb_top;
	import acpr_pkg::*;
	localparam int COLD = 20;
	logic clock, rst_n, clk_en, avs_read, avs_write, avs_waitrequest;
	logic [ADDR_WIDTH-1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	logic strap_a, strap_b, ate_mode, vendor_mode, frame_start;
	logic bit_clk_out, bit_clk_oe, sdata_in_out, sdata_in_oe, own_bclk, bclk_wire;
	logic link_reset_n, sync, sdo;
	acpr_pd_type powerdown;
	acpr_ready_type ready;
	acpr_mode_type codec_mode;
	logic [5:0] pd;
	int n_mismatch, total_checks, c;
	assign bclk_wire = bit_clk_oe ? bit_clk_out : own_bclk;
	acpr_ctrl #(.COLD_CYCLES(COLD)) i_acpr_ctrl (.clock(clock), .rst_n(rst_n),
		.clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .link_reset_n_pin(link_reset_n),
		.sync_pin(sync), .sdata_out_pin(sdo), .bit_clk_in(bclk_wire),
		.bit_clk_out(bit_clk_out), .bit_clk_oe(bit_clk_oe), .sdata_in_out(sdata_in_out),
		.sdata_in_oe(sdata_in_oe), .codec_select_strap_a(strap_a),
		.codec_select_strap_b(strap_b), .powerdown(powerdown), .ready(ready),
		.codec_mode(codec_mode), .ate_mode(ate_mode), .vendor_mode(vendor_mode),
		.frame_start(frame_start));
	acpr_link_partner i_acpr_link_partner (.clock(clock), .bclk(bclk_wire),
		.own_bclk(own_bclk), .link_reset_n(link_reset_n), .sync(sync), .sdo(sdo));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= ~wr;
		avs_write <= wr;
		for (int i = 0; i < 20; i++) begin
			@(posedge clock);
			if (avs_waitrequest === 1'b0) begin
				q = avs_readdata;
				avs_read <= 1'b0;
				avs_write <= 1'b0;
				return;
			end
		end
		n_mismatch++;
		summarize();
	endtask
	task automatic rd_check(input logic [9:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hf, rd);
		check(rd, e);
	endtask
	task automatic wait_state(input logic [2:0] st);
		for (int i = 0; i < 2000; i++) begin
			bus(1'b0, 10'h0c0, 32'h0, 4'hf, rd);
			if (rd[6:4] === st) return;
		end
		n_mismatch++;
		summarize();
	endtask
	task automatic wait_frame();
		for (int i = 0; i < 3000; i++) begin
			@(posedge clock);
			if (frame_start === 1'b1) begin
				check({31'h0, frame_start}, 32'h1);
				return;
			end
		end
		n_mismatch++;
		summarize();
	endtask
	task automatic count_to_clock(output int n);
		n = 0;
		while (bit_clk_out !== 1'b1 && n < 200) begin
			@(posedge clock);
			n++;
		end
	endtask
	function automatic logic [31:0] pd_word(input logic [5:0] p);
		logic r;
		r = ~p[3];
		return {18'h0, p, 4'h0, r, ~p[2] & r, ~p[1] & r, ~p[0] & r};
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		{rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
		{clk_en, strap_a, strap_b, avs_byteenable} = 7'h7f;
		n_mismatch = 0;
		total_checks = 0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		i_acpr_link_partner.cold_reset(1'b0, 1'b0);
		count_to_clock(c);
		check({31'h0, c + 9 > COLD && c + 9 < COLD + 12}, 32'h1);
		check({30'h0, bit_clk_oe, sdata_in_oe}, 32'h3);
		rd_check(10'h098, 32'h0000_000f);
		rd_check(10'h3fc, READ_UNMAPPED);
		bus(1'b1, 10'h098, 32'h0000_3f00, 4'h1, rd);
		rd_check(10'h098, 32'h0000_000f);
		i_acpr_link_partner.start_frames(1'b0);
		wait_frame();
		// Full shutdown, one bit per write, ascending
		for (int k = 0; k < 6; k++) begin
			pd = 6'((1 << (k + 1)) - 1);
			rd_check(10'h098, pd_word(pd >> 1));
			bus(1'b1, 10'h098, {18'h0, pd, 8'h0}, 4'h2, rd);
			rd_check(10'h098, pd_word(pd));
			check({26'h0, powerdown}, {26'h0, pd});
			check({28'h0, ready}, pd_word(pd) & 32'h0000_000f);
			if (k == 4) begin
				wait_state(ST_DOWN);
				repeat (60) begin
					@(posedge clock);
					check({30'h0, bit_clk_out, sdata_in_out}, 32'h0);
				end
			end
		end
		i_acpr_link_partner.warm_reset();
		count_to_clock(c);
		check({31'h0, c >= WARM_WAIT_CYCLES && c < 40}, 32'h1);
		// Clock enable low freezes the running bit clock
		clk_en <= 1'b0;
		@(posedge clock);
		rd = {31'h0, bit_clk_out};
		repeat (8) begin
			@(posedge clock);
			check({31'h0, bit_clk_out}, rd);
		end
		clk_en <= 1'b1;
		rd_check(10'h098, pd_word(6'h2f));
		i_acpr_link_partner.cold_reset(1'b0, 1'b0);
		rd_check(10'h098, pd_word(6'h00));
		for (int k = 0; k < 4; k++) begin
			strap_a <= !k[0];
			strap_b <= !k[1];
			i_acpr_link_partner.cold_reset(1'b0, 1'b0);
			bus(1'b0, 10'h0c0, 32'h0, 4'hf, rd);
			check({30'h0, rd[1:0]}, 32'(k));
			check({31'h0, bit_clk_oe}, {31'h0, k == 0});
			check({30'h0, codec_mode}, 32'(k));
		end
		// Secondary 3 on an external bit clock
		i_acpr_link_partner.start_frames(1'b1);
		repeat (3) wait_frame();
		bus(1'b0, 10'h0c0, 32'h0, 4'hf, rd);
		check({16'h0, rd[31:16]}, 32'h9ac5);
		{strap_a, strap_b} <= 2'h3;
		i_acpr_link_partner.cold_reset(1'b1, 1'b0);
		check({29'h0, ate_mode, sdata_in_oe, bit_clk_oe}, 32'h4);
		i_acpr_link_partner.cold_reset(1'b0, 1'b1);
		check({30'h0, vendor_mode, ate_mode}, 32'h2);
		summarize();
	end
endmodule
`default_nettype wire
